// ==== pumis_level_quant.sv ====
// quantiser of one strap code into one of seven levels
// assumes a code already brought into the clock domain
`default_nettype none
module pumis_level_quant
   import pumis_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [ADC_W-1:0] i_code,
   output logic [LVL_W-1:0] o_level
);
   logic [LVL_W-1:0] level_next;
   logic [LVL_W-1:0] level_reg;

   // thermometer compare, exactly one level per code
   assign level_next = (i_code >= LVL_TH6) ? 3'h6 :
                       (i_code >= LVL_TH5) ? 3'h5 :
                       (i_code >= LVL_TH4) ? 3'h4 :
                       (i_code >= LVL_TH3) ? 3'h3 :
                       (i_code >= LVL_TH2) ? 3'h2 :
                       (i_code >= LVL_TH1) ? 3'h1 : 3'h0;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         level_reg <= 3'h0;
      end else begin
         level_reg <= level_next;
      end
   end

   assign o_level = level_reg;
endmodule
`default_nettype wire

// ==== pumis_nvm_model.sv ====
// memory partner: flag word and program word, prompt or slow acks
// assumes the device holds its request until acked
`default_nettype none
module pumis_nvm_model
   import pumis_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_slow,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [NVM_AW-1:0] i_addr,
   input wire logic [NVM_DW-1:0] i_wdata,
   output logic o_ack,
   output logic [NVM_DW-1:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NVM_DW-1:0] flag_word;
   logic [NVM_DW-1:0] prog_word;
   logic [NVM_DW-1:0] word_sel;
   int cnt = 0;
   assign word_sel = (i_addr == NVM_FLAG_ADDR) ? flag_word : (i_addr == NVM_PROG_ADDR) ? prog_word : NVM_ERASED;
   initial begin
      o_ack = 1'b0;
      o_rdata = 16'h0000;
   end
   always @(posedge i_clk_sys) begin
      // released data lines never show a stale word two cycles in a row
      o_rdata <= ~o_rdata;
      if (o_ack) begin
         o_ack <= 1'b0;
         cnt <= 0;
      end else if (i_req) begin
         if (cnt >= (i_slow ? 5 : 0)) begin
            o_ack <= 1'b1;
            if (i_we && i_addr == NVM_FLAG_ADDR) flag_word <= i_wdata;
            if (!i_we) o_rdata <= word_sel;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== pumis_pkg.sv ====
// constants, carriers and register map of the power-up mode and node id selector
// assumes one 40 MHz clock and a synchronous reset that is asserted at power-up only
// Overview of operation
// - The three strap inputs are sampled once after power-up and only the captured values are used afterwards.
// - Each strap input resolves to exactly one of seven levels, zero tied low up to six tied high.
// - A high strap at level zero, one or two selects the open CANopen protocol mode.
// - A high strap at level three to six selects the motion-script CAN protocol mode.
// - The node id is 49 times (high level minus 3) plus 7 times the mid level plus the low level.
// - Each level enters the node id sum as its index, 0 for the lowest up to 6 for the highest.
// - A computed node id of zero is replaced by 255.
// - In motion-script CAN mode automatic run is the default after power-up.
// - Under automatic run the stored motion program is started when one is present in the memory.
// - A value of 1 in the memory word at 0x4000 disables automatic run at every later power-up.
// - All Hall inputs low at power-up forces slave mode without automatic run.
// - A stored disable flag forces slave mode without automatic run regardless of the Hall inputs.
`default_nettype none
package pumis_pkg;
   localparam int ADC_W = 10;
   localparam int LVL_W = 3;
   localparam int NUM_LEVELS = 7;
   localparam int HALL_W = 3;
   localparam int NVM_AW = 16;
   localparam int NVM_DW = 16;
   // level boundaries on the strap code, lowest first
   localparam logic [ADC_W-1:0] LVL_TH1 = 10'h049;
   localparam logic [ADC_W-1:0] LVL_TH2 = 10'h0DB;
   localparam logic [ADC_W-1:0] LVL_TH3 = 10'h16D;
   localparam logic [ADC_W-1:0] LVL_TH4 = 10'h292;
   localparam logic [ADC_W-1:0] LVL_TH5 = 10'h324;
   localparam logic [ADC_W-1:0] LVL_TH6 = 10'h3B6;
   localparam logic [LVL_W-1:0] LVL_SCRIPT_MIN = 3'h3;
   localparam logic [9:0] ID_W_HIGH = 10'h031;
   localparam logic [9:0] ID_W_MID = 10'h007;
   localparam logic [9:0] ID_HIGH_BIAS = 10'h003;
   localparam logic [7:0] ID_ZERO_SUBST = 8'hFF;
   // memory words
   localparam logic [NVM_AW-1:0] NVM_FLAG_ADDR = 16'h4000;
   localparam logic [NVM_AW-1:0] NVM_PROG_ADDR = 16'h4001;
   localparam logic [NVM_DW-1:0] NVM_FLAG_DISABLE = 16'h0001;
   localparam logic [NVM_DW-1:0] NVM_ERASED = 16'hFFFF;
   localparam logic [NVM_DW-1:0] NVM_EMPTY = 16'h0000;
   // timing
   localparam int CLK_HZ = 40000000;
   localparam int SETTLE_US = 100;
   localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000) < 1) ? 1 : SETTLE_US * (CLK_HZ / 1000000);
   localparam int STABLE_SAMPLES = 8;
   // registers, byte addresses
   localparam int AV_AW = 4;
   localparam logic [AV_AW-1:0] REG_STATUS = 4'h0;
   localparam logic [AV_AW-1:0] REG_NODE_ID = 4'h4;
   localparam logic [AV_AW-1:0] REG_LEVELS = 4'h8;
   localparam logic [AV_AW-1:0] REG_CONTROL = 4'hC;
   localparam int CTRL_DISABLE_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam logic [31:0] REG_RST = 32'h00000000;

   typedef struct packed {
      logic [LVL_W-1:0] high_mode;
      logic [LVL_W-1:0] mid;
      logic [LVL_W-1:0] low;
   } pumis_levels_t;

   typedef struct packed {
      logic done;
      logic script_mode;
      logic autorun;
      logic slave;
      logic prog_present;
      logic flag_stored;
      logic hall_override;
      logic nvm_busy;
      logic [7:0] node_id;
   } pumis_cfg_t;

   typedef enum logic [2:0] {
      ST_SETTLE = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_RD_FLAG = 3'b010,
      ST_RD_PROG = 3'b011,
      ST_DONE = 3'b100,
      ST_WR_FLAG = 3'b101
   } pumis_state_t;
endpackage
`default_nettype wire

// ==== pumis_top.sv ====
// power-up strap capture, protocol mode, node id and automatic run decision
// assumes straps come as converter codes and Hall pins asynchronous; memory port on i_clk_sys
`default_nettype none
module pumis_top
   import pumis_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [ADC_W-1:0] i_id_strap_low,
   input wire logic [ADC_W-1:0] i_id_strap_mid,
   input wire logic [ADC_W-1:0] i_id_strap_high_mode,
   input wire logic [HALL_W-1:0] i_hall,
   output logic o_nvm_req,
   output logic o_nvm_we,
   output logic [NVM_AW-1:0] o_nvm_addr,
   output logic [NVM_DW-1:0] o_nvm_wdata,
   input wire logic i_nvm_ack,
   input wire logic [NVM_DW-1:0] i_nvm_rdata,
   output logic o_cfg_done,
   output logic o_motion_script_can_mode,
   output logic o_autorun,
   output logic o_slave_mode,
   output logic [7:0] o_node_id,
   output logic o_prog_start,
   input wire logic [AV_AW-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest
);
   // synchronisers for pin-side inputs
   logic [ADC_W-1:0] low_s1_reg;
   logic [ADC_W-1:0] low_s2_reg;
   logic [ADC_W-1:0] mid_s1_reg;
   logic [ADC_W-1:0] mid_s2_reg;
   logic [ADC_W-1:0] high_s1_reg;
   logic [ADC_W-1:0] high_s2_reg;
   logic [HALL_W-1:0] hall_s1_reg;
   logic [HALL_W-1:0] hall_s2_reg;

   // multi-bit codes may tear here; the stability window before capture hides it
   always_ff @(posedge i_clk_sys) begin
      low_s1_reg <= i_id_strap_low;
      low_s2_reg <= low_s1_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      mid_s1_reg <= i_id_strap_mid;
      mid_s2_reg <= mid_s1_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      high_s1_reg <= i_id_strap_high_mode;
      high_s2_reg <= high_s1_reg;
   end

   always_ff @(posedge i_clk_sys) begin
      hall_s1_reg <= i_hall;
      hall_s2_reg <= hall_s1_reg;
   end

   pumis_levels_t live_lvl;

   pumis_level_quant u_q_low (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_code(low_s2_reg),
      .o_level(live_lvl.low)
   );

   pumis_level_quant u_q_mid (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_code(mid_s2_reg),
      .o_level(live_lvl.mid)
   );

   pumis_level_quant u_q_high (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_code(high_s2_reg),
      .o_level(live_lvl.high_mode)
   );

   // state
   pumis_state_t state_reg;
   pumis_state_t state_next;
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   pumis_levels_t prev_lvl_reg;
   pumis_levels_t cap_lvl_reg;
   pumis_levels_t cap_lvl_next;
   logic [HALL_W-1:0] cap_hall_reg;
   logic [HALL_W-1:0] cap_hall_next;
   pumis_cfg_t cfg_reg;
   pumis_cfg_t cfg_next;
   logic start_reg;
   logic start_next;
   logic wr_pend_reg;
   logic wr_pend_next;

   // memory port
   logic nvm_req_reg;
   logic nvm_we_reg;
   logic [NVM_AW-1:0] nvm_addr_reg;
   logic [NVM_DW-1:0] nvm_wdata_reg;
   logic nvm_req_next;
   logic nvm_we_next;
   logic [NVM_AW-1:0] nvm_addr_next;
   logic [NVM_DW-1:0] nvm_wdata_next;

   // bus
   logic av_ack_reg;
   logic [31:0] av_rdata_reg;
   logic [31:0] av_rdata_next;
   logic ctrl_enable_reg;

   // derived decisions
   wire logic settle_done = (cnt_reg >= 32'(SETTLE_CYCLES - 1));
   wire logic lvl_stable = (live_lvl == prev_lvl_reg);
   wire logic samples_done = (cnt_reg >= 32'(STABLE_SAMPLES - 1));
   wire logic script_mode_w = (cap_lvl_reg.high_mode >= LVL_SCRIPT_MIN);
   wire logic hall_all_low = (cap_hall_reg == '0);
   wire logic flag_set_w = (i_nvm_rdata == NVM_FLAG_DISABLE);
   wire logic prog_ok_w = (i_nvm_rdata != NVM_ERASED) && (i_nvm_rdata != NVM_EMPTY);
   wire logic nvm_done = nvm_req_reg & i_nvm_ack;
   // one term for autorun, slave and start, so the three never disagree
   wire logic autorun_w = script_mode_w & ~cfg_reg.flag_stored & ~hall_all_low;

   // node id from captured levels, signed sum kept in its low eight bits
   wire logic [9:0] id_high_term = 10'((10'(cap_lvl_reg.high_mode) - ID_HIGH_BIAS) * ID_W_HIGH);
   wire logic [9:0] id_mid_term = 10'(10'(cap_lvl_reg.mid) * ID_W_MID);
   wire logic [9:0] id_sum = 10'(id_high_term + id_mid_term + 10'(cap_lvl_reg.low));
   wire logic [7:0] id_raw = id_sum[7:0];
   wire logic [7:0] id_final = (id_raw == 8'h00) ? ID_ZERO_SUBST : id_raw;

   // bus decode
   wire logic av_req = (i_avs_read | i_avs_write) & ~av_ack_reg;
   wire logic hit_status = (i_avs_address == REG_STATUS);
   wire logic hit_node = (i_avs_address == REG_NODE_ID);
   wire logic hit_levels = (i_avs_address == REG_LEVELS);
   wire logic hit_ctrl = (i_avs_address == REG_CONTROL);
   wire logic ctrl_wr = i_avs_write & hit_ctrl & i_avs_byteenable[0];
   wire logic disable_req = ctrl_wr & i_avs_writedata[CTRL_DISABLE_BIT];
   // a disable request waits until the power-up sequence is over
   wire logic bus_stall = disable_req & ((state_reg != ST_DONE) | wr_pend_reg);
   wire logic av_take = av_req & ~bus_stall;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cap_lvl_next = cap_lvl_reg;
      cap_hall_next = cap_hall_reg;
      cfg_next = cfg_reg;
      start_next = 1'b0;
      wr_pend_next = wr_pend_reg;
      nvm_req_next = nvm_req_reg;
      nvm_we_next = nvm_we_reg;
      nvm_addr_next = nvm_addr_reg;
      nvm_wdata_next = nvm_wdata_reg;
      case (state_reg)
         ST_SETTLE: begin
            // supply and strap dividers need time before the levels mean anything
            cnt_next = cnt_reg + 32'h00000001;
            if (settle_done) begin
               cnt_next = '0;
               state_next = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            // levels must agree for several cycles before the one capture
            if (!lvl_stable) begin
               cnt_next = '0;
            end else if (samples_done) begin
               cap_lvl_next = live_lvl;
               cap_hall_next = hall_s2_reg;
               cnt_next = '0;
               nvm_req_next = 1'b1;
               nvm_we_next = 1'b0;
               nvm_addr_next = NVM_FLAG_ADDR;
               state_next = ST_RD_FLAG;
            end else begin
               cnt_next = cnt_reg + 32'h00000001;
            end
         end
         ST_RD_FLAG: begin
            if (nvm_done) begin
               cfg_next.flag_stored = flag_set_w;
               nvm_addr_next = NVM_PROG_ADDR;
               state_next = ST_RD_PROG;
            end
         end
         ST_RD_PROG: begin
            if (nvm_done) begin
               nvm_req_next = 1'b0;
               cfg_next.prog_present = prog_ok_w;
               cfg_next.script_mode = script_mode_w;
               cfg_next.hall_override = hall_all_low;
               cfg_next.node_id = id_final;
               // script mode defaults to autorun unless flag or Hall override
               cfg_next.autorun = autorun_w;
               cfg_next.slave = ~autorun_w;
               cfg_next.done = 1'b1;
               // start the stored program only when there is one
               start_next = autorun_w & prog_ok_w;
               state_next = ST_DONE;
            end
         end
         ST_DONE: begin
            // decision frozen; only the stored flag may still change
            if (wr_pend_reg) begin
               nvm_req_next = 1'b1;
               nvm_we_next = 1'b1;
               nvm_addr_next = NVM_FLAG_ADDR;
               nvm_wdata_next = NVM_FLAG_DISABLE;
               cfg_next.nvm_busy = 1'b1;
               state_next = ST_WR_FLAG;
            end
         end
         ST_WR_FLAG: begin
            // flag takes effect at the next power-up only
            if (nvm_done) begin
               nvm_req_next = 1'b0;
               nvm_we_next = 1'b0;
               wr_pend_next = 1'b0;
               cfg_next.nvm_busy = 1'b0;
               state_next = ST_DONE;
            end
         end
         default: begin
            state_next = ST_SETTLE;
            cnt_next = '0;
         end
      endcase
      if (av_take & disable_req & ctrl_enable_reg) begin
         wr_pend_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_reg <= ST_SETTLE;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // previous levels for the stability window
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         prev_lvl_reg <= '0;
      end else begin
         prev_lvl_reg <= live_lvl;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         cap_lvl_reg <= '0;
         cap_hall_reg <= '0;
         cfg_reg <= '0;
         start_reg <= 1'b0;
         wr_pend_reg <= 1'b0;
      end else begin
         cap_lvl_reg <= cap_lvl_next;
         cap_hall_reg <= cap_hall_next;
         cfg_reg <= cfg_next;
         start_reg <= start_next;
         wr_pend_reg <= wr_pend_next;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         nvm_req_reg <= 1'b0;
         nvm_we_reg <= 1'b0;
         nvm_addr_reg <= '0;
         nvm_wdata_reg <= '0;
      end else begin
         nvm_req_reg <= nvm_req_next;
         nvm_we_reg <= nvm_we_next;
         nvm_addr_reg <= nvm_addr_next;
         nvm_wdata_reg <= nvm_wdata_next;
      end
   end

   // register read mux; unmapped reads return zero
   always_comb begin
      av_rdata_next = REG_RST;
      if (hit_status) begin
         av_rdata_next = {21'h000000, cap_hall_reg, cfg_reg[15:8]};
      end else if (hit_node) begin
         av_rdata_next = {24'h000000, cfg_reg.node_id};
      end else if (hit_levels) begin
         av_rdata_next = {23'h000000, cap_lvl_reg};
      end else if (hit_ctrl) begin
         av_rdata_next = {30'h00000000, ctrl_enable_reg, wr_pend_reg};
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         av_ack_reg <= 1'b0;
         ctrl_enable_reg <= 1'b0;
      end else begin
         av_ack_reg <= av_take;
         if (av_take & ctrl_wr) begin
            ctrl_enable_reg <= i_avs_writedata[CTRL_ENABLE_BIT];
         end
      end
   end

   // read data holds until the next read is taken, so a late master still finds it
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         av_rdata_reg <= REG_RST;
      end else if (av_take & i_avs_read) begin
         av_rdata_reg <= av_rdata_next;
      end
   end

   // one wait cycle per access, more while a flag write is held off
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~av_ack_reg;
   assign o_avs_readdata = av_rdata_reg;

   assign o_nvm_req = nvm_req_reg;
   assign o_nvm_we = nvm_we_reg;
   assign o_nvm_addr = nvm_addr_reg;
   assign o_nvm_wdata = nvm_wdata_reg;
   assign o_cfg_done = cfg_reg.done;
   assign o_motion_script_can_mode = cfg_reg.script_mode;
   assign o_autorun = cfg_reg.autorun;
   assign o_slave_mode = cfg_reg.slave;
   assign o_node_id = cfg_reg.node_id;
   assign o_prog_start = start_reg;
endmodule
`default_nettype wire

// ==== pumis_top_properties.sv ====
// checker of the selector outputs and its memory port
// assumes the pumis_top port set and one clock domain
`default_nettype none
module pumis_checker
   import pumis_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic o_nvm_req,
   input wire logic o_nvm_we,
   input wire logic [NVM_AW-1:0] o_nvm_addr,
   input wire logic [NVM_DW-1:0] o_nvm_wdata,
   input wire logic i_nvm_ack,
   input wire logic o_cfg_done,
   input wire logic o_motion_script_can_mode,
   input wire logic o_autorun,
   input wire logic o_slave_mode,
   input wire logic [7:0] o_node_id,
   input wire logic o_prog_start,
   input wire logic i_avs_read,
   input wire logic o_avs_waitrequest
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   property p_nvm_hold;
      o_nvm_req && !i_nvm_ack |=> o_nvm_req && $stable(o_nvm_addr) && $stable(o_nvm_we) && $stable(o_nvm_wdata);
   endproperty
   a_nvm_hold: assert property (p_nvm_hold) else $error("memory request changed before ack");
   property p_first_read;
      $rose(o_nvm_req) && !o_nvm_we |-> o_nvm_addr == NVM_FLAG_ADDR;
   endproperty
   a_first_read: assert property (p_first_read) else $error("first read not at flag word");
   property p_read_order;
      o_nvm_req && i_nvm_ack && !o_nvm_we && o_nvm_addr == NVM_FLAG_ADDR
         |=> o_nvm_req && !o_nvm_we && o_nvm_addr == NVM_PROG_ADDR;
   endproperty
   a_read_order: assert property (p_read_order) else $error("program word not read after flag");
   property p_flag_write;
      o_nvm_req && o_nvm_we |-> o_nvm_addr == NVM_FLAG_ADDR && o_nvm_wdata == NVM_FLAG_DISABLE;
   endproperty
   a_flag_write: assert property (p_flag_write) else $error("bad flag write");
   property p_cfg_hold;
      o_cfg_done |=> o_cfg_done && $stable(o_node_id) && $stable(o_motion_script_can_mode) && $stable(o_autorun);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("decision changed after done");
   property p_auto_script;
      o_autorun |-> o_motion_script_can_mode && o_cfg_done;
   endproperty
   a_auto_script: assert property (p_auto_script) else $error("autorun outside script mode");
   property p_slave;
      o_cfg_done |-> o_slave_mode != o_autorun;
   endproperty
   a_slave: assert property (p_slave) else $error("slave and autorun disagree");
   property p_id_nonzero;
      o_cfg_done |-> o_node_id != 8'h00;
   endproperty
   a_id_nonzero: assert property (p_id_nonzero) else $error("node id zero");
   property p_start_pulse;
      o_prog_start |-> o_autorun ##1 !o_prog_start;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("bad program start pulse");
   property p_wait;
      $rose(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("read answer not after one cycle");
   c_start: cover property (o_prog_start);
   c_flag_wr: cover property (o_nvm_req && o_nvm_we && i_nvm_ack);
   c_slave: cover property ($rose(o_cfg_done) && o_slave_mode);
endmodule
bind pumis_top pumis_checker i_pumis_checker (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .o_nvm_req(o_nvm_req),
   .o_nvm_we(o_nvm_we), .o_nvm_addr(o_nvm_addr), .o_nvm_wdata(o_nvm_wdata), .i_nvm_ack(i_nvm_ack),
   .o_cfg_done(o_cfg_done), .o_motion_script_can_mode(o_motion_script_can_mode), .o_autorun(o_autorun),
   .o_slave_mode(o_slave_mode), .o_node_id(o_node_id), .o_prog_start(o_prog_start),
   .i_avs_read(i_avs_read), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// ==== pumis_top_test.sv ====
// bench: power-up cases, register reads and the flag write
// assumes the memory model and the bound checker
`default_nettype none
module pumis_top_test;
   import pumis_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] CODE [7] = '{10'h020, 10'h090, 10'h120, 10'h200, 10'h2D0, 10'h360, 10'h3E0};
   logic i_clk_sys = 1'b0;
   logic i_srst = 1'b1;
   logic [ADC_W-1:0] s_low = '0, s_mid = '0, s_high = '0;
   logic [HALL_W-1:0] hall = 3'h7;
   logic av_rd = 1'b0, av_wr = 1'b0, slow = 1'b0;
   logic [AV_AW-1:0] av_addr = '0;
   logic [3:0] av_be = 4'hF;
   logic [31:0] av_wdata = '0, av_rdata, rdata;
   logic nvm_req, nvm_we, nvm_ack, done, mode, autorun, slave, pstart, waitreq;
   logic [NVM_AW-1:0] nvm_addr;
   logic [NVM_DW-1:0] nvm_wdata, nvm_rdata;
   logic [7:0] node_id;
   int miscompares = 0, n_tests = 0, n_start = 0, rst_len = 16;
   pumis_top #(.SETTLE_CYCLES(8)) i_pumis_top (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
      .i_id_strap_low(s_low), .i_id_strap_mid(s_mid), .i_id_strap_high_mode(s_high), .i_hall(hall),
      .o_nvm_req(nvm_req), .o_nvm_we(nvm_we), .o_nvm_addr(nvm_addr), .o_nvm_wdata(nvm_wdata),
      .i_nvm_ack(nvm_ack), .i_nvm_rdata(nvm_rdata), .o_cfg_done(done), .o_motion_script_can_mode(mode),
      .o_autorun(autorun), .o_slave_mode(slave), .o_node_id(node_id), .o_prog_start(pstart),
      .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
      .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(waitreq));
   pumis_nvm_model i_pumis_nvm_model (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_req(nvm_req), .i_we(nvm_we),
      .i_addr(nvm_addr), .i_wdata(nvm_wdata), .o_ack(nvm_ack), .o_rdata(nvm_rdata));
   initial forever #12.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) if (pstart === 1'b1) n_start <= n_start + 1;
   task automatic end_sim();
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic av_cycle(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk_sys);
      av_rd <= !wr;
      av_wr <= wr;
      av_addr <= a;
      av_wdata <= d;
      do begin
         @(posedge i_clk_sys);
         n++;
      end while (waitreq !== 1'b0 && n < 200);
      rdata = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
      if (n >= 200) miscompares++;
   endtask
   task automatic power_up(input logic [2:0] h, m, l, hl, input logic [15:0] pw, input logic sl);
      int v, k;
      logic sc, au;
      @(posedge i_clk_sys);
      s_high <= CODE[h];
      s_mid <= CODE[m];
      s_low <= CODE[l];
      hall <= hl;
      slow <= sl;
      i_srst <= 1'b1;
      i_pumis_nvm_model.prog_word = pw;
      repeat (rst_len) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      rst_len = 4;
      n_start = 0;
      k = 0;
      while (done !== 1'b1 && k < 400) begin
         @(posedge i_clk_sys);
         k++;
      end
      repeat (3) @(posedge i_clk_sys);
      v = (49 * (int'(h) - 3) + 7 * int'(m) + int'(l)) & 255;
      if (v == 0) v = 255;
      sc = h >= 3;
      au = sc && i_pumis_nvm_model.flag_word !== NVM_FLAG_DISABLE && hl !== 3'h0;
      chk_bit(done, 1'b1);
      chk_bit(mode, sc);
      chk_word({24'h0, node_id}, v);
      chk_bit(autorun, au);
      chk_bit(slave, !au);
      chk_word(n_start, au && pw != NVM_EMPTY && pw != NVM_ERASED);
      av_cycle(1'b0, REG_LEVELS, 32'h0);
      chk_word(rdata, {23'h0, h, m, l});
      av_cycle(1'b0, REG_NODE_ID, 32'h0);
      chk_word(rdata, v);
      av_cycle(1'b0, REG_STATUS, 32'h0);
      chk_word(rdata, {21'h0, hl, 1'b1, sc, au, !au, pw != NVM_EMPTY && pw != NVM_ERASED,
         i_pumis_nvm_model.flag_word === NVM_FLAG_DISABLE, hl === 3'h0, 1'b0});
      s_high <= ~CODE[h];
      s_low <= ~CODE[l];
      hall <= ~hl;
      repeat (20) @(posedge i_clk_sys);
      chk_word({24'h0, node_id}, v);
      chk_bit(mode, sc);
   endtask
   initial begin
      i_pumis_nvm_model.flag_word = 16'h0000;
      power_up(3'h0, 3'h0, 3'h0, 3'h7, 16'h1234, 1'b0);
      power_up(3'h3, 3'h0, 3'h0, 3'h7, 16'h1234, 1'b1);
      power_up(3'h6, 3'h6, 3'h6, 3'h0, 16'h1234, 1'b0);
      power_up(3'h5, 3'h2, 3'h3, 3'h5, 16'hFFFF, 1'b1);
      power_up(3'h2, 3'h4, 3'h5, 3'h7, 16'h1234, 1'b0);
      power_up(3'h1, 3'h3, 3'h4, 3'h2, 16'h0000, 1'b1);
      i_pumis_nvm_model.flag_word = 16'h0001;
      power_up(3'h4, 3'h5, 3'h1, 3'h7, 16'h1234, 1'b0);
      i_pumis_nvm_model.flag_word = 16'h0000;
      av_cycle(1'b1, REG_CONTROL, 32'h1);
      repeat (20) @(posedge i_clk_sys);
      chk_word(i_pumis_nvm_model.flag_word, 32'h0);
      av_cycle(1'b1, REG_CONTROL, 32'h2);
      av_cycle(1'b1, REG_CONTROL, 32'h3);
      repeat (20) @(posedge i_clk_sys);
      chk_word(i_pumis_nvm_model.flag_word, 32'h1);
      av_cycle(1'b0, REG_CONTROL, 32'h0);
      chk_word(rdata, 32'h2);
      av_cycle(1'b0, 4'h2, 32'h0);
      chk_word(rdata, 32'h0);
      power_up(3'h4, 3'h5, 3'h1, 3'h7, 16'h1234, 1'b1);
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      miscompares++;
      end_sim();
   end
endmodule
`default_nettype wire
